// ---- design/rtcc_top.sv ----
// AXI4-Lite slave and control decode for one retimer channel slice.
`timescale 1ns/1ps
`default_nettype none
module rtcc_top
    import rtcc_pkg::*;
#(
    parameter int ADDR_W = 8 // Byte address width.
)
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Companion start bits and manual tap enable from other registers.
    input wire logic pattern_start_a,
    input wire logic pattern_start_b,
    input wire logic manual_tap_enable,
    // Adaptive equalizer values used outside manual mode.
    input wire logic [4:0] adapt_tap_pol,
    input wire logic [4:0] adapt_tap1_weight,
    // Raw signal detect from the analog comparator.
    input wire logic raw_signal_detect,
    // Pattern generator and eye monitor controls.
    output logic pattern_start,
    output logic [13:0] eye_monitor_step_uv,
    output logic eye_monitor_power_down,
    // Feedback equalizer controls; bit 4 is tap 1, bit 0 is tap 5.
    output logic [4:0] feedback_equalizer_tap_pol,
    output logic [4:0] feedback_equalizer_tap1_weight,
    output logic neg_transconductance_sel,
    // Offset loop, boost limiting and mode.
    output logic dc_offset_enable,
    output logic linear_equalizer_boost_limit,
    output logic wavelength_multiplex_mode,
    // Signal detect result and reference levels.
    output logic signal_detect,
    output logic [1:0] sd_assert_level,
    output logic [1:0] sd_deassert_level
);

    // The top index signal_detect_control needs five index bits above the word offset, seven address bits in all.
    if (ADDR_W < 7 || ADDR_W > 32)
    begin : g_check
        $error("rtcc_top: ADDR_W must be from 7 to 32");
    end

    rtcc_reg_if rif ();

    // Register storage lives in its own module.
    rtcc_reg_bank u_bank (
        .aclk (aclk),
        .aresetn (aresetn),
        .rif (rif)
    );

    // Address decode: word index, then range check against the map.
    wire [ADDR_W-3:0] wr_index = s_axi_awaddr[ADDR_W-1:2];
    wire [ADDR_W-3:0] rd_index = s_axi_araddr[ADDR_W-1:2];
    // Bounds are cut to the index width so both sides of each compare match.
    wire wr_hit = wr_index >= (ADDR_W-2)'(IDX_FIRST) &&
        wr_index <= (ADDR_W-2)'(IDX_SIG_DETECT);
    wire rd_hit = rd_index >= (ADDR_W-2)'(IDX_FIRST) &&
        rd_index <= (ADDR_W-2)'(IDX_SIG_DETECT);
    wire [2:0] wr_slot = 3'(wr_index - (ADDR_W-2)'(IDX_FIRST));
    wire [2:0] rd_slot = 3'(rd_index - (ADDR_W-2)'(IDX_FIRST));

    // Response registers.
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [7:0] rdata_reg;
    // Hit flag of the write address one cycle earlier, for the response check below.
    logic wr_hit_d;

    // Address and data are taken together, so neither can be stranded.
    // A new write waits until the previous response has been accepted.
    wire wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
    wire rd_take = s_axi_arvalid && !rvalid_reg;

    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign s_axi_arready = rd_take;

    // Only byte lane 0 carries data; a write with it masked stores nothing.
    assign rif.wr_en = wr_take && wr_hit && s_axi_wstrb[0];
    assign rif.wr_sel = wr_slot;
    assign rif.wr_data = s_axi_wdata[7:0];
    assign rif.rd_sel = rd_slot;

    // Write response, one cycle after the take, held until bready.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else if (wr_take)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read response, data captured at the take and held until rready.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 8'h00;
        end
        else if (rd_take)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_reg <= rd_hit ? rif.rd_data : 8'h00;
        end
        else if (s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = {24'h000000, rdata_reg};

    // Named views of the stored bytes.
    wire [7:0] shift_byte = rif.regs[3'(IDX_PATTERN_SHIFT - IDX_FIRST)];
    wire [7:0] eye_byte = rif.regs[3'(IDX_EYE_TAP_POL - IDX_FIRST)];
    wire [7:0] tap1_byte = rif.regs[3'(IDX_TAP_ONE - IDX_FIRST)];
    wire [7:0] ob_byte = rif.regs[3'(IDX_OFFSET_BOOST - IDX_FIRST)];
    wire [7:0] sd_byte = rif.regs[3'(IDX_SIG_DETECT - IDX_FIRST)];

    // The generator runs only with all three start bits high; ordering
    // of the writes is left to software, which sets shift enable last.
    assign pattern_start = shift_byte[BIT_SHIFT_EN] &&
        pattern_start_a && pattern_start_b;

    // Eye monitor range decode.
    wire [1:0] eye_range = eye_byte[BIT_EYE_RANGE_HI:BIT_EYE_RANGE_LO];
    assign eye_monitor_step_uv =
        (eye_range == 2'h0) ? EYE_STEP_UV_0 :
        (eye_range == 2'h1) ? EYE_STEP_UV_1 :
        (eye_range == 2'h2) ? EYE_STEP_UV_2 : EYE_STEP_UV_3;
    assign eye_monitor_power_down = eye_byte[BIT_EYE_PD];

    // Manual tap polarity and weight reach the equalizer only while manual mode is on.
    wire [4:0] manual_pol = {tap1_byte[BIT_TAP1_POL],
        eye_byte[BIT_TAP_POL_HI:0]};
    assign feedback_equalizer_tap_pol =
        manual_tap_enable ? manual_pol : adapt_tap_pol;
    assign feedback_equalizer_tap1_weight = manual_tap_enable ?
        tap1_byte[BIT_TAP1_W_HI:0] : adapt_tap1_weight;
    assign neg_transconductance_sel = tap1_byte[BIT_NEG_TRANSCOND];

    // Offset loop, boost limit and mode bits.
    assign dc_offset_enable = ob_byte[BIT_DC_OFFSET];
    assign linear_equalizer_boost_limit = ob_byte[BIT_BOOST_LIMIT];
    assign wavelength_multiplex_mode = ob_byte[BIT_WDM];

    // Signal detect forcing; force off is checked first so it wins.
    wire force_on = sd_byte[BIT_FORCE_ON];
    wire force_off = sd_byte[BIT_FORCE_OFF];
    assign signal_detect = force_off ? 1'b0 :
        force_on ? 1'b1 : raw_signal_detect;
    assign sd_assert_level =
        sd_byte[BIT_SD_ASSERT_HI:BIT_SD_ASSERT_LO];
    assign sd_deassert_level =
        sd_byte[BIT_SD_DEASSERT_HI:BIT_SD_DEASSERT_LO];

    // Checks of the steering outputs against their stored causes, and of the bus handshakes.
    property p_start;
        @(posedge aclk) disable iff (!aresetn)
        pattern_start |-> shift_byte[BIT_SHIFT_EN] && pattern_start_a &&
            pattern_start_b;
    endproperty
    a_start: assert property (p_start)
        else $error("pattern start without shift enable");

    property p_eye_range;
        @(posedge aclk) disable iff (!aresetn)
        eye_range == 2'h3 |-> eye_monitor_step_uv == EYE_STEP_UV_3;
    endproperty
    a_eye_range: assert property (p_eye_range)
        else $error("eye step wrong for top range");

    property p_eye_pd;
        @(posedge aclk)
        !aresetn |=> eye_monitor_power_down;
    endproperty
    a_eye_pd: assert property (p_eye_pd)
        else $error("eye monitor not powered down after reset");

    property p_tap_auto;
        @(posedge aclk) disable iff (!aresetn)
        !manual_tap_enable |-> feedback_equalizer_tap_pol == adapt_tap_pol;
    endproperty
    a_tap_auto: assert property (p_tap_auto)
        else $error("manual polarity leaked outside manual mode");

    property p_tap1_w;
        @(posedge aclk) disable iff (!aresetn)
        manual_tap_enable |->
            feedback_equalizer_tap1_weight == tap1_byte[BIT_TAP1_W_HI:0];
    endproperty
    a_tap1_w: assert property (p_tap1_w)
        else $error("tap 1 weight not from register in manual mode");

    property p_dc_rst;
        @(posedge aclk)
        !aresetn |=> dc_offset_enable && neg_transconductance_sel;
    endproperty
    a_dc_rst: assert property (p_dc_rst)
        else $error("offset loop or transconductance reset wrong");

    property p_sd_off;
        @(posedge aclk) disable iff (!aresetn)
        force_off |-> !signal_detect;
    endproperty
    a_sd_off: assert property (p_sd_off)
        else $error("signal detect high while forced off");

    property p_sd_on;
        @(posedge aclk) disable iff (!aresetn)
        force_on && !force_off |-> signal_detect;
    endproperty
    a_sd_on: assert property (p_sd_on)
        else $error("signal detect low while forced on");

    property p_wr_resp;
        @(posedge aclk) disable iff (!aresetn)
        wr_take |=> s_axi_bvalid && s_axi_bresp == (wr_hit_d ?
            RESP_OKAY : RESP_SLVERR);
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response missing or wrong");

    property p_rd_hold;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data dropped before rready");

    property p_wr_refuse;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_refuse: assert property (p_wr_refuse)
        else $error("write taken while a response is pending");

    property p_rd_refuse;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rd_refuse: assert property (p_rd_refuse)
        else $error("read taken while read data is pending");

    property p_rst_resp;
        @(posedge aclk)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst_resp: assert property (p_rst_resp)
        else $error("bus response pending after reset");

    property p_tap1_pol;
        @(posedge aclk) disable iff (!aresetn)
        manual_tap_enable |->
            feedback_equalizer_tap_pol[4] == tap1_byte[BIT_TAP1_POL];
    endproperty
    a_tap1_pol: assert property (p_tap1_pol)
        else $error("tap 1 polarity not from register in manual mode");

    property p_mode_rst;
        @(posedge aclk)
        !aresetn |=> !wavelength_multiplex_mode &&
            !linear_equalizer_boost_limit;
    endproperty
    a_mode_rst: assert property (p_mode_rst)
        else $error("boost limit or mode bit set after reset");

    // Helper for the write response check: hit flag of the taken write.
    always_ff @(posedge aclk)
    begin
        wr_hit_d <= wr_hit;
    end

endmodule : rtcc_top
`default_nettype wire

// ---- design/rtcc_pkg.sv ----
// Package with the register map, field positions and step sizes.
package rtcc_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_PATTERN_SHIFT = 8'h0d;
    localparam logic [7:0] IDX_RSVD_A = 8'h0e;
    localparam logic [7:0] IDX_RSVD_B = 8'h0f;
    localparam logic [7:0] IDX_RSVD_C = 8'h10;
    localparam logic [7:0] IDX_EYE_TAP_POL = 8'h11;
    localparam logic [7:0] IDX_TAP_ONE = 8'h12;
    localparam logic [7:0] IDX_OFFSET_BOOST = 8'h13;
    localparam logic [7:0] IDX_SIG_DETECT = 8'h14;
    localparam logic [7:0] IDX_FIRST = IDX_PATTERN_SHIFT;
    localparam int NREG = 8;

    // Reset values in index order, first entry at IDX_FIRST.
    localparam logic [7:0] RST_VALUES [NREG] = '{
        8'h00, 8'h93, 8'h69, 8'h3a, 8'h20, 8'ha0, 8'h90, 8'h00
    };

    // Field positions.
    localparam int BIT_SHIFT_EN = 5;
    localparam int BIT_EYE_RANGE_HI = 7;
    localparam int BIT_EYE_RANGE_LO = 6;
    localparam int BIT_EYE_PD = 5;
    localparam int BIT_TAP_POL_HI = 3;
    localparam int BIT_TAP1_POL = 7;
    localparam int BIT_NEG_TRANSCOND = 5;
    localparam int BIT_TAP1_W_HI = 4;
    localparam int BIT_DC_OFFSET = 4;
    localparam int BIT_BOOST_LIMIT = 2;
    localparam int BIT_WDM = 1;
    localparam int BIT_FORCE_ON = 7;
    localparam int BIT_FORCE_OFF = 6;
    localparam int BIT_SD_ASSERT_HI = 5;
    localparam int BIT_SD_ASSERT_LO = 4;
    localparam int BIT_SD_DEASSERT_HI = 3;
    localparam int BIT_SD_DEASSERT_LO = 2;

    // Eye monitor step sizes in microvolts.
    localparam logic [13:0] EYE_STEP_UV_0 = 14'h0c35;
    localparam logic [13:0] EYE_STEP_UV_1 = 14'h186a;
    localparam logic [13:0] EYE_STEP_UV_2 = 14'h249f;
    localparam logic [13:0] EYE_STEP_UV_3 = 14'h30d4;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rtcc_pkg

// ---- design/rtcc_reg_if.sv ----
// Interface joining the bus slave to the register bank.
`timescale 1ns/1ps
`default_nettype none
interface rtcc_reg_if;
    import rtcc_pkg::*;
    logic wr_en; // One-cycle write strobe.
    logic [2:0] wr_sel; // Register slot written.
    logic [7:0] wr_data; // Byte written.
    logic [2:0] rd_sel; // Register slot read.
    logic [7:0] rd_data; // Byte read back.
    logic [NREG-1:0][7:0] regs; // All stored bytes.

    modport bank (input wr_en, input wr_sel, input wr_data, input rd_sel,
                  output rd_data, output regs);
    modport user (output wr_en, output wr_sel, output wr_data,
                  output rd_sel, input rd_data, input regs);
endinterface : rtcc_reg_if
`default_nettype wire

// ---- design/rtcc_reg_bank.sv ----
// Storage for the eight channel control bytes.
`timescale 1ns/1ps
`default_nettype none
module rtcc_reg_bank
    import rtcc_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register port.
    rtcc_reg_if.bank rif
);

    // Stored bytes; every bit, reserved ones too, is writable.
    logic [NREG-1:0][7:0] regs_reg;

    // Reset loads printed defaults; a write replaces the whole byte.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                regs_reg[i] <= RST_VALUES[i];
            end
        end
        else if (rif.wr_en)
        begin
            regs_reg[rif.wr_sel] <= rif.wr_data;
        end
    end

    // Read selection is plain combinational.
    assign rif.rd_data = regs_reg[rif.rd_sel];
    assign rif.regs = regs_reg;

endmodule : rtcc_reg_bank
`default_nettype wire

// ---- bench/rtcc_testbench.sv ----
// Self-checking testbench for the retimer channel control register slice.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rtcc_pkg::*;
;
    // Clock, reset and bus signals driven by the bench.
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    // Bus outputs of the design.
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    // Side inputs of the design.
    logic start_a = 1'b0, start_b = 1'b0, manual = 1'b0, raw_sd = 1'b0;
    logic [4:0] adapt_pol = 5'h00, adapt_w = 5'h00;
    // Control outputs of the design.
    logic pat_start, eye_pd, neg_tc, dc_en, boost_lim, wdm, sd;
    logic [13:0] eye_step;
    logic [4:0] tap_pol, tap1_w;
    logic [1:0] sd_as, sd_de;
    // Counters for the verdict and the hang guard.
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [7:0] v;
    // Printed reset values, index order from the first mapped register.
    logic [7:0] rst_tbl [8] = '{8'h00, 8'h93, 8'h69, 8'h3a,
                                8'h20, 8'ha0, 8'h90, 8'h00};

    rtcc_top #(.ADDR_W(8)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pattern_start_a(start_a), .pattern_start_b(start_b),
        .manual_tap_enable(manual), .adapt_tap_pol(adapt_pol),
        .adapt_tap1_weight(adapt_w), .raw_signal_detect(raw_sd),
        .pattern_start(pat_start), .eye_monitor_step_uv(eye_step),
        .eye_monitor_power_down(eye_pd),
        .feedback_equalizer_tap_pol(tap_pol),
        .feedback_equalizer_tap1_weight(tap1_w),
        .neg_transconductance_sel(neg_tc), .dc_offset_enable(dc_en),
        .linear_equalizer_boost_limit(boost_lim),
        .wavelength_multiplex_mode(wdm), .signal_detect(sd),
        .sd_assert_level(sd_as), .sd_deassert_level(sd_de)
    );

    // Free-running 25 MHz clock.
    initial
    begin
        forever #20 aclk = ~aclk;
    end

    // Prints the verdict and stops the run.
    task automatic finish_test();
        $display("Counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    // The whole run needs well under a thousand cycles.
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            finish_test();
        end
    end

    // Compares one result and reports a mismatch at once.
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] seen);
        compares = compares + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Writes one byte to a register index and checks the response.
    task automatic wr(input logic [7:0] idx, input logic [7:0] data,
                      input logic [3:0] strb, input logic [1:0] exp);
        awaddr <= {idx[5:0], 2'b00};
        wdata <= {24'h0, data};
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(posedge aclk);
        while (!(awready === 1'b1 && wready === 1'b1)) @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        check("bresp", 32'(exp), 32'(bresp));
        bready <= 1'b0;
        // Let an edge pass so a following call never drives bready twice.
        @(posedge aclk);
    endtask : wr

    // Reads one register index, returning data and response.
    task automatic rd_reg(input logic [7:0] idx, output logic [31:0] data,
                          output logic [1:0] resp);
        araddr <= {idx[5:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
        // Let an edge pass so a following call never drives rready twice.
        @(posedge aclk);
    endtask : rd_reg

    // Reads and compares a mapped register.
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        rd_reg(idx, rd, rs);
        check("rdata", {24'h0, exp}, rd);
        check("rresp", 32'(RESP_OKAY), 32'(rs));
    endtask : rd_chk

    // Main sequence; companion inputs always change before shift enable.
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values and reset state of the controls.
        for (int i = 0; i < 8; i++)
            rd_chk(8'(IDX_FIRST + i), rst_tbl[i]);
        check("eye_pd", 32'h1, 32'(eye_pd));
        check("eye_step", 32'd3125, 32'(eye_step));
        check("neg_tc", 32'h1, 32'(neg_tc));
        check("dc_en", 32'h1, 32'(dc_en));
        check("boost", 32'h0, 32'(boost_lim));
        check("wdm", 32'h0, 32'(wdm));
        check("tap1_w", 32'h0, 32'(tap1_w));
        $display("Test reset values done");
        // Unmapped places and a write with its byte lane off.
        wr(8'h15, 8'h55, 4'hf, RESP_SLVERR);
        rd_reg(8'h0c, rd, rs);
        check("unmapped rdata", 32'h0, rd);
        check("unmapped rresp", 32'(RESP_SLVERR), 32'(rs));
        wr(IDX_RSVD_A, 8'h11, 4'he, RESP_OKAY);
        rd_chk(IDX_RSVD_A, 8'h93);
        for (int i = 1; i < 4; i++)
        begin
            wr(8'(IDX_FIRST + i), ~rst_tbl[i], 4'h1, RESP_OKAY);
            rd_chk(8'(IDX_FIRST + i), ~rst_tbl[i]);
        end
        // A read with rready held low must keep its answer standing.
        araddr <= {IDX_TAP_ONE[5:0], 2'b00};
        arvalid <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        repeat (3) @(posedge aclk);
        check("rvalid held", 32'h1, 32'(rvalid));
        check("rdata held", {24'h0, rst_tbl[5]}, rdata);
        rready <= 1'b1;
        @(posedge aclk);
        rready <= 1'b0;
        @(posedge aclk);
        check("rvalid dropped", 32'h0, 32'(rvalid));
        $display("Test bus access done");
        // Pattern start needs all three bits; shift enable goes last.
        for (int i = 0; i < 4; i++)
        begin
            start_a <= i[0];
            start_b <= i[1];
            wr(IDX_PATTERN_SHIFT, 8'h20, 4'h1, RESP_OKAY);
            check("pat_start", 32'(i == 3), 32'(pat_start));
            wr(IDX_PATTERN_SHIFT, 8'h00, 4'h1, RESP_OKAY);
            check("pat_start off", 32'h0, 32'(pat_start));
        end
        $display("Test pattern start done");
        // Every eye range code, monitor powered up.
        for (int r = 0; r < 4; r++)
        begin
            wr(IDX_EYE_TAP_POL, {r[1:0], 6'h00}, 4'h1, RESP_OKAY);
            check("eye_step", 32'(3125 * (r + 1)), 32'(eye_step));
            check("eye_pd", 32'h0, 32'(eye_pd));
        end
        $display("Test eye monitor done");
        // Manual taps against adaptive values.
        wr(IDX_EYE_TAP_POL, 8'h2a, 4'h1, RESP_OKAY);
        wr(IDX_TAP_ONE, 8'h15, 4'h1, RESP_OKAY);
        check("eye_pd", 32'h1, 32'(eye_pd));
        check("neg_tc", 32'h0, 32'(neg_tc));
        adapt_pol <= 5'h13;
        adapt_w <= 5'h0c;
        @(posedge aclk);
        check("tap_pol auto", 32'h13, 32'(tap_pol));
        check("tap1_w auto", 32'h0c, 32'(tap1_w));
        manual <= 1'b1;
        @(posedge aclk);
        check("tap_pol man", 32'h0a, 32'(tap_pol));
        check("tap1_w man", 32'h15, 32'(tap1_w));
        wr(IDX_TAP_ONE, 8'h9f, 4'h1, RESP_OKAY);
        check("tap_pol man", 32'h1a, 32'(tap_pol));
        check("tap1_w man", 32'h1f, 32'(tap1_w));
        $display("Test equalizer taps done");
        // Offset loop, boost limit and mode bits one at a time.
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h10 : (i == 2) ? 8'h04 : 8'h02;
            wr(IDX_OFFSET_BOOST, v, 4'h1, RESP_OKAY);
            check("dc_en", 32'(v[4]), 32'(dc_en));
            check("boost", 32'(v[2]), 32'(boost_lim));
            check("wdm", 32'(v[1]), 32'(wdm));
        end
        $display("Test offset and mode done");
        // Force bits against both raw levels, with all reference codes.
        for (int i = 0; i < 8; i++)
        begin
            raw_sd <= i[0];
            v = {i[2], i[1], i[1:0], ~i[1:0], 2'b00};
            wr(IDX_SIG_DETECT, v, 4'h1, RESP_OKAY);
            check("sd", 32'(i[1] ? 1'b0 : (i[2] | i[0])),
                  32'(sd));
            check("sd_as", 32'(i[1:0]), 32'(sd_as));
            // The concatenation keeps the inversion to two bits.
            check("sd_de", {30'h0, ~i[1:0]}, 32'(sd_de));
        end
        $display("Test signal detect done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
